// *** logic/wdsc_pkg.sv ***
// package: constants, register map and carrier types of the watchdog/sleep block
// Overview of operation
// RULE1 - watchdog counts own oscillator, also during sleep
// RULE2 - timeout while running resets the device
// RULE3 - timeout while asleep wakes and resumes execution
// RULE4 - any timeout clears the timeout flag
// RULE5 - enable config bit zero disables watchdog
// RULE6 - option register assigns prescaler and ratio
// RULE7 - clear or sleep resets watchdog and prescaler
// RULE8 - clear zeroes prescaler count, keeps its settings
// RULE9 - sleep clears watchdog, powerdown flag, stops oscillator
// RULE10 - ports hold their drive state in sleep
// RULE11 - wake by master reset, timeout or interrupt
// RULE12 - powerdown flag set at powerup, cleared by sleep
// RULE13 - eight listed peripheral interrupts may wake
// RULE14 - clocked-only peripherals cannot wake the device
// RULE15 - next address prefetched while sleep executes
// RULE16 - wake needs source enable, ignores global enable
// RULE17 - after wake run next, then vector if enabled
// RULE18 - pending enabled interrupt makes sleep a no-op
// RULE19 - interrupt during sleep: finish sleep, then wake
// RULE20 - crystal modes wait 1024 oscillator periods on wake
// RULE21 - program verify only without code protection
// RULE22 - four id words only in program mode
// RULE23 - timeout period set by width and prescale
package wdsc_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_OPTION = 16'h0081;
    localparam logic [15:0] IDX_CONFIG = 16'h2007;
    localparam logic [15:0] IDX_ID0 = 16'h2000;
    localparam logic [15:0] IDX_STATUS = 16'h0040;
    localparam logic [15:0] IDX_CTRL = 16'h0041;
    localparam int ID_WORDS = 4;
    // option fields
    localparam int OPT_PSA = 3;
    localparam int OPT_PS_LSB = 0;
    // configuration fields
    localparam int CFG_WATCHDOG_ENABLE_CFG = 2;
    localparam int CFG_CP_LSB = 4;
    localparam int CFG_OSC_LSB = 0;
    localparam logic [1:0] OSC_RC = 2'b11;
    localparam logic [1:0] CP_NONE = 2'b11;
    // status and control fields
    localparam int STS_PD = 3;
    localparam int STS_TO = 4;
    localparam int STS_SLEEP = 0;
    localparam int CTRL_PROG = 0;
    // reset values
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic [7:0] CONFIG_RST = 8'hFF;
    // oscillator start-up: 1024 main oscillator periods
    localparam int OST_TOSC = 1024;
    localparam int TOSC_NS = 10;
    localparam int CLK_NS = 10;
    localparam int OST_CYC = (OST_TOSC * TOSC_NS + CLK_NS - 1) / CLK_NS;
    // wake source positions
    localparam int WAKE_SRCS = 8;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_OST = 2'b10
    } wdsc_state_t;
    // instruction requests from the core
    typedef struct packed {
        logic clear_watchdog_instr;
        logic sleep;
        logic global_irq_enable;
    } wdsc_core_t;
endpackage

// *** logic/wdsc_sync.sv ***
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module wdsc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    // shift chain; only s2 reads s1
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end else begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    // level changes once the last two stages agree
    always_ff @(posedge clk) begin
        if (rst) begin
            level <= INIT;
        end else begin
            level <= (s2_r == s3_r) ? s3_r : level;
        end
    end
    assign rise = (s2_r & s3_r) & ~level;
endmodule // wdsc_sync
`default_nettype wire

// *** logic/wdsc_id_mem.sv ***
// small word memory holding the identification words
`timescale 1ns/1ps
`default_nettype none
module wdsc_id_mem #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [$clog2(D)-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [$clog2(D)-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [D];
    // write port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
    // registered read port
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule // wdsc_id_mem
`default_nettype wire

// *** logic/wdsc_top.sv ***
// watchdog, sleep and wake control with apb registers
`timescale 1ns/1ps
`default_nettype none
module wdsc_top
    import wdsc_pkg::*;
#(
    parameter int WD_W = 8,
    parameter int PC_W = 13,
    parameter int PORT_W = 8,
    parameter int ID_W = 8,
    parameter logic [WAKE_SRCS-1:0] WAKE_CAPABLE = 8'hFF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wdOscIn,
    input wire logic masterResetN,
    input wire wdsc_pkg::wdsc_core_t core,
    input wire logic [PC_W-1:0] pcIn,
    input wire logic [WAKE_SRCS-1:0] irqFlag,
    input wire logic [WAKE_SRCS-1:0] irqEnable,
    input wire logic [PORT_W-1:0] portDrive,
    input wire logic [PORT_W-1:0] portDriveOe,
    output logic [PORT_W-1:0] portOut,
    output logic [PORT_W-1:0] portOe,
    output logic deviceReset,
    output logic oscDriverOn,
    output logic coreRun,
    output logic wakeResume,
    output logic wakeToVector,
    output logic [PC_W-1:0] resumePc,
    output logic pmVerifyEn
);
    import wdsc_pkg::*;

    // index decode, shared by read and write paths
    function automatic logic isId(input logic [15:0] a);
        return (a[1:0] == 2'b00) && (a[15:2] >= IDX_ID0[13:0])
            && (a[15:2] < IDX_ID0[13:0] + 14'(ID_WORDS));
    endfunction
    function automatic logic isIdx(input logic [15:0] a, input logic [15:0] idx);
        return (a[1:0] == 2'b00) && (a[15:2] == idx[13:0]);
    endfunction

    wdsc_state_t state_r;
    wdsc_state_t state_nxt;
    logic [7:0] option_r;
    logic [7:0] config_r;
    logic ctrlProg_r;
    logic toN_r;
    logic pdN_r;
    logic [6:0] preCnt_r;
    logic [WD_W-1:0] wdCnt_r;
    logic [10:0] ostCnt_r;
    logic [31:0] prdata_r;
    logic [ID_W-1:0] idRdata;
    logic [1:0] pinLevel;
    logic [1:0] pinRise;
    logic oscTick;
    logic mclrLow;
    logic wdEnable;
    logic [6:0] preMax;
    logic wdStep;
    logic wdTimeout;
    logic clrExec;
    logic sleepExec;
    logic wdClear;
    logic pendAny;
    logic irqWake;
    logic wakeEv;
    logic rcMode;
    logic apbSetup;
    logic apbWr;
    logic idHit;
    logic mapped;

    // pin inputs: watchdog oscillator and master reset
    wdsc_sync #(.W(2), .INIT(2'b10)) u_sync (
        .clk(clk),
        .rst(rst),
        .pinIn({masterResetN, wdOscIn}),
        .level(pinLevel),
        .rise(pinRise)
    );
    assign oscTick = pinRise[0]; // RULE1
    assign mclrLow = ~pinLevel[1];

    // instruction decode and wake qualification
    assign wdEnable = config_r[CFG_WATCHDOG_ENABLE_CFG]; // RULE5
    assign rcMode = (config_r[CFG_OSC_LSB +: 2] == OSC_RC);
    assign pendAny = |(irqFlag & irqEnable); // RULE16
    assign irqWake = |(irqFlag & irqEnable & WAKE_CAPABLE); // RULE13 RULE14 RULE16
    assign clrExec = core.clear_watchdog_instr && (state_r == ST_RUN);
    assign sleepExec = core.sleep && (state_r == ST_RUN) && !pendAny; // RULE18
    assign wdClear = clrExec | sleepExec | deviceReset; // RULE7

    // prescaler ratio 1:2^ps when assigned to the watchdog
    assign preMax = 7'((8'd1 << option_r[OPT_PS_LSB +: 3]) - 8'd1); // RULE6
    assign wdStep = oscTick && (!option_r[OPT_PSA] || (preCnt_r == preMax));
    assign wdTimeout = wdEnable && !wdClear && wdStep && (&wdCnt_r); // RULE23
    assign wakeEv = (state_r == ST_SLEEP) && (irqWake || wdTimeout); // RULE3 RULE11

    // prescaler count; clearing leaves option settings alone
    always_ff @(posedge clk) begin
        if (rst) begin
            preCnt_r <= '0;
        end else if ((wdClear && option_r[OPT_PSA]) || !option_r[OPT_PSA]) begin
            preCnt_r <= '0; // RULE7 RULE8
        end else if (oscTick && wdEnable) begin
            preCnt_r <= (preCnt_r == preMax) ? 7'd0 : preCnt_r + 7'd1;
        end
    end

    // watchdog counter keeps running in every state
    always_ff @(posedge clk) begin
        if (rst) begin
            wdCnt_r <= '0;
        end else if (wdClear || !wdEnable) begin
            wdCnt_r <= '0; // RULE7 RULE9
        end else if (wdStep) begin
            wdCnt_r <= wdCnt_r + 1'b1; // RULE1
        end
    end

    // device reset from master reset pin or running timeout
    always_ff @(posedge clk) begin
        if (rst) begin
            deviceReset <= 1'b0;
        end else begin
            deviceReset <= mclrLow || (wdTimeout && state_r != ST_SLEEP); // RULE2 RULE11
        end
    end

    // status flags, hardware events win over clears
    always_ff @(posedge clk) begin
        if (rst) begin
            toN_r <= 1'b1;
            pdN_r <= 1'b1; // RULE12
        end else begin
            if (wdTimeout) begin
                toN_r <= 1'b0; // RULE4
            end else if (sleepExec || clrExec) begin
                toN_r <= 1'b1; // RULE9
            end
            if (sleepExec) begin
                pdN_r <= 1'b0; // RULE9 RULE12
            end else if (clrExec || (wdTimeout && state_r != ST_SLEEP)) begin
                pdN_r <= 1'b1;
            end
        end
    end

    // sleep state machine
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_RUN: begin
                if (sleepExec) begin
                    state_nxt = ST_SLEEP; // RULE19
                end
            end
            ST_SLEEP: begin
                if (wakeEv) begin
                    state_nxt = rcMode ? ST_RUN : ST_OST; // RULE20
                end
            end
            ST_OST: begin
                if (ostCnt_r == 11'(OST_CYC - 1)) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst || deviceReset) begin
            state_r <= ST_RUN; // RULE11
        end else begin
            state_r <= state_nxt;
        end
    end

    // oscillator start-up counter
    always_ff @(posedge clk) begin
        if (rst || state_r != ST_OST) begin
            ostCnt_r <= '0;
        end else begin
            ostCnt_r <= ostCnt_r + 11'd1; // RULE20
        end
    end

    // oscillator driver off only while asleep
    always_ff @(posedge clk) begin
        if (rst) begin
            oscDriverOn <= 1'b1;
        end else begin
            oscDriverOn <= (state_nxt != ST_SLEEP) || deviceReset; // RULE9
        end
    end
    assign coreRun = (state_r == ST_RUN);

    // wake report: resume in line, vector only if globally enabled
    always_ff @(posedge clk) begin
        if (rst) begin
            wakeResume <= 1'b0;
            wakeToVector <= 1'b0;
        end else begin
            wakeResume <= (state_r != ST_RUN) && (state_nxt == ST_RUN) && !deviceReset;
            wakeToVector <= (state_r != ST_RUN) && (state_nxt == ST_RUN) && !deviceReset
                && core.global_irq_enable && pendAny; // RULE17
        end
    end

    // prefetched address of the instruction after sleep
    always_ff @(posedge clk) begin
        if (rst) begin
            resumePc <= '0;
        end else if (sleepExec) begin
            resumePc <= pcIn + 1'b1; // RULE15
        end
    end

    // port drive frozen while the core is stopped
    always_ff @(posedge clk) begin
        if (rst) begin
            portOut <= '0;
            portOe <= '0;
        end else if (state_r == ST_RUN && !sleepExec) begin
            portOut <= portDrive;
            portOe <= portDriveOe;
        end else if (sleepExec) begin
            portOut <= portDrive; // RULE10
            portOe <= portDriveOe;
        end
    end

    // program memory readout gate
    always_ff @(posedge clk) begin
        if (rst) begin
            pmVerifyEn <= 1'b0;
        end else begin
            pmVerifyEn <= ctrlProg_r && (config_r[CFG_CP_LSB +: 2] == CP_NONE); // RULE21
        end
    end

    // apb decode; every access completes in one access cycle
    assign apbSetup = psel && !penable;
    assign apbWr = psel && penable && pwrite && !pslverr;
    assign idHit = isId(paddr);
    assign mapped = isIdx(paddr, IDX_OPTION) || isIdx(paddr, IDX_CONFIG)
        || isIdx(paddr, IDX_STATUS) || isIdx(paddr, IDX_CTRL);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(mapped || (idHit && ctrlProg_r)); // RULE22

    // option register steers the prescaler
    always_ff @(posedge clk) begin
        if (rst) begin
            option_r <= OPTION_RST;
        end else if (apbWr && isIdx(paddr, IDX_OPTION)) begin
            option_r <= pwdata[7:0]; // RULE6
        end
    end

    // configuration word, changed only in program mode
    always_ff @(posedge clk) begin
        if (rst) begin
            config_r <= CONFIG_RST;
        end else if (apbWr && ctrlProg_r && isIdx(paddr, IDX_CONFIG)) begin
            config_r <= pwdata[7:0];
        end
    end

    // program/verify mode control
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlProg_r <= 1'b0;
        end else if (apbWr && isIdx(paddr, IDX_CTRL)) begin
            ctrlProg_r <= pwdata[CTRL_PROG];
        end
    end

    // identification words
    wdsc_id_mem #(.W(ID_W), .D(ID_WORDS)) u_idmem (
        .clk(clk),
        .rst(rst),
        .we(apbWr && idHit), // RULE22
        .waddr(paddr[3:2]),
        .wdata(pwdata[ID_W-1:0]),
        .raddr(paddr[3:2]),
        .rdata(idRdata)
    );

    // read data captured in the setup cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_r <= '0;
        end else if (apbSetup) begin
            prdata_r <= '0;
            if (isIdx(paddr, IDX_OPTION)) begin
                prdata_r[7:0] <= option_r;
            end else if (isIdx(paddr, IDX_CONFIG)) begin
                prdata_r[7:0] <= config_r;
            end else if (isIdx(paddr, IDX_STATUS)) begin
                prdata_r[STS_TO] <= toN_r;
                prdata_r[STS_PD] <= pdN_r;
                prdata_r[STS_SLEEP] <= (state_r != ST_RUN);
            end else if (isIdx(paddr, IDX_CTRL)) begin
                prdata_r[CTRL_PROG] <= ctrlProg_r;
            end
        end
    end
    assign prdata = (idHit && ctrlProg_r) ? 32'(idRdata) : prdata_r;

    // checks
    sequence s_enter;
        sleepExec;
    endsequence
    sequence s_lateIrq;
        (state_r == ST_SLEEP) && irqWake;
    endsequence
    property p_wdReset;
        @(posedge clk) disable iff (rst) wdTimeout && state_r == ST_RUN |=> deviceReset;
    endproperty
    a_wdReset: assert property (p_wdReset) else $error("timeout gave no reset"); // RULE2
    property p_toClr;
        @(posedge clk) disable iff (rst) wdTimeout |=> !toN_r;
    endproperty
    a_toClr: assert property (p_toClr) else $error("timeout flag not cleared"); // RULE4
    property p_off;
        @(posedge clk) disable iff (rst) !wdEnable |-> !wdTimeout ##1 wdCnt_r == '0;
    endproperty
    a_off: assert property (p_off) else $error("disabled watchdog counted"); // RULE5
    property p_clr;
        @(posedge clk) disable iff (rst) clrExec |=> wdCnt_r == '0 && $stable(option_r[3:0]);
    endproperty
    a_clr: assert property (p_clr) else $error("clear mishandled"); // RULE8
    property p_sleepFx;
        @(posedge clk) disable iff (rst) s_enter |=> !pdN_r && !oscDriverOn && wdCnt_r <= 1;
    endproperty
    a_sleepFx: assert property (p_sleepFx) else $error("sleep side effects missing"); // RULE9
    property p_hold;
        @(posedge clk) disable iff (rst) state_r != ST_RUN && $past(state_r) != ST_RUN
            |-> $stable(portOut) && $stable(portOe);
    endproperty
    a_hold: assert property (p_hold) else $error("port moved in sleep"); // RULE10
    property p_pc;
        @(posedge clk) disable iff (rst) s_enter |=> resumePc == $past(pcIn) + 1'b1;
    endproperty
    a_pc: assert property (p_pc) else $error("wrong resume address"); // RULE15
    property p_nop;
        @(posedge clk) disable iff (rst) core.sleep && coreRun && pendAny && !deviceReset
            |=> state_r == ST_RUN;
    endproperty
    a_nop: assert property (p_nop) else $error("sleep not a no-op"); // RULE18
    property p_late;
        @(posedge clk) disable iff (rst) s_enter ##1 s_lateIrq |=> state_r != ST_SLEEP;
    endproperty
    a_late: assert property (p_late) else $error("no wake after sleep"); // RULE19
    property p_ost;
        @(posedge clk) disable iff (rst || deviceReset) state_r == ST_SLEEP && state_nxt == ST_OST
            |=> (state_r == ST_OST)[*8];
    endproperty
    a_ost: assert property (p_ost) else $error("start-up delay skipped"); // RULE20
    property p_verify;
        @(posedge clk) disable iff (rst) $past(config_r[5:4]) != 2'b11 |-> !pmVerifyEn;
    endproperty
    a_verify: assert property (p_verify) else $error("verify under protection"); // RULE21
endmodule // wdsc_top
`default_nettype wire

// *** sim/wdsc_core_model.sv ***
// partner model: the core that issues clear, sleep and interrupt levels
`timescale 1ns/1ps
`default_nettype none
module wdsc_core_model
    import wdsc_pkg::*;
(
    input wire logic clk,
    output var wdsc_pkg::wdsc_core_t core,
    output logic [12:0] pcIn,
    output logic [7:0] irqFlag,
    output logic [7:0] irqEnable,
    output logic [7:0] portDrive,
    output logic [7:0] portDriveOe
);
    // idle core: no instruction, no flags
    initial begin
        core = '0;
        pcIn = 13'h0000;
        irqFlag = 8'h00;
        irqEnable = 8'h00;
        portDrive = 8'h00;
        portDriveOe = 8'h00;
    end
    // one instruction lasts exactly one cycle
    task automatic pulse(input logic c, input logic s);
        @(posedge clk);
        core.clear_watchdog_instr <= c;
        core.sleep <= s;
        @(posedge clk);
        core.clear_watchdog_instr <= 1'b0;
        core.sleep <= 1'b0;
    endtask
    // level inputs change just after an edge
    task automatic set(input logic g, input logic [12:0] pc, input logic [7:0] f,
                       input logic [7:0] e, input logic [7:0] d, input logic [7:0] o);
        @(posedge clk);
        core.global_irq_enable <= g;
        pcIn <= pc;
        irqFlag <= f;
        irqEnable <= e;
        portDrive <= d;
        portDriveOe <= o;
    endtask
endmodule // wdsc_core_model
`default_nettype wire

// *** sim/tb_watchdog_sleep_wake_control.sv ***
// bench: registers, watchdog, sleep and wake of the watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_sleep_wake_control;
    import wdsc_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err, hit, seen;
    logic wdOscIn, rstPinN, devRst, oscOn, run, wake, toVec, pmv;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] wdDiv;
    logic [12:0] pc, rpc;
    logic [7:0] flg, en, pd, po, pOut, pOe, oh;
    wdsc_core_t core;
    int miscompares, samplesChecked, n;

    wdsc_top #(.WD_W(3)) uut (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdOscIn(wdOscIn), .masterResetN(rstPinN), .core(core),
        .pcIn(pc), .irqFlag(flg), .irqEnable(en), .portDrive(pd), .portDriveOe(po),
        .portOut(pOut), .portOe(pOe), .deviceReset(devRst), .oscDriverOn(oscOn),
        .coreRun(run), .wakeResume(wake), .wakeToVector(toVec), .resumePc(rpc),
        .pmVerifyEn(pmv));
    wdsc_core_model partner (
        .clk(clk), .core(core), .pcIn(pc), .irqFlag(flg), .irqEnable(en),
        .portDrive(pd), .portDriveOe(po));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watchdog oscillator, four clocks a period, also during sleep
    always @(posedge clk) begin
        wdDiv <= wdDiv + 2'h1;
        wdOscIn <= wdDiv[1];
    end
    // remembers any device reset since last cleared
    always @(posedge clk) begin
        if (devRst === 1'b1) begin
            seen <= 1'b1;
        end
    end
    // hang guard
    initial begin
        #300000;
        miscompares++;
        wrapUp();
    end

    task automatic wrapUp();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkBit(input logic g, input logic e);
        chk({31'h0, g}, {31'h0, e});
    endtask
    task automatic done(input string s);
        $display("test %0s done", s);
    endtask
    // one apb transfer; data and error taken at the pready edge
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx[13:0], 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            miscompares++;
        end
    endtask
    task automatic rdChk(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(rd, exp);
    endtask
    // waits for wake pulse or device reset, bounded
    task automatic waitFor(input logic useWake, input int lim, output int c, output logic h);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while ((useWake ? wake : devRst) !== 1'b1 && c < lim);
        h = (useWake ? wake : devRst) === 1'b1;
    endtask
    task automatic clearSeen();
        @(negedge clk);
        seen = 1'b0;
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        rstPinN = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        wdDiv = 2'h0;
        wdOscIn = 1'b0;
        seen = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdChk(IDX_OPTION, 32'h0000_00FF);
        rdChk(IDX_STATUS, 32'h0000_0018);
        apb(1'b1, IDX_CONFIG, 32'h0000_0000);
        rdChk(IDX_CONFIG, 32'h0000_00FF);
        apb(1'b0, IDX_ID0, 32'h0000_0000);
        chkBit(err, 1'b1);
        apb(1'b0, 16'h0010, 32'h0000_0000);
        chkBit(err, 1'b1);
        done("registers");
        // ratio 1: eight ticks; ratio 2: sixteen
        apb(1'b1, IDX_OPTION, 32'h0000_0008);
        rdChk(IDX_OPTION, 32'h0000_0008);
        partner.pulse(1'b1, 1'b0);
        waitFor(1'b0, 200, n, hit);
        chkBit(n >= 20 && n <= 44, 1'b1);
        rdChk(IDX_STATUS, 32'h0000_0008);
        apb(1'b1, IDX_OPTION, 32'h0000_0009);
        partner.pulse(1'b1, 1'b0);
        waitFor(1'b0, 200, n, hit);
        chkBit(n >= 48 && n <= 76, 1'b1);
        apb(1'b1, IDX_OPTION, 32'h0000_0008);
        partner.pulse(1'b1, 1'b0);
        rdChk(IDX_STATUS, 32'h0000_0018);
        partner.pulse(1'b1, 1'b0);
        clearSeen();
        repeat (8) begin
            repeat (10) @(posedge clk);
            partner.pulse(1'b1, 1'b0);
        end
        chkBit(seen, 1'b0);
        done("watchdog");
        // sleep, frozen ports, then wake by watchdog
        partner.set(1'b0, 13'h0123, 8'h00, 8'h00, 8'hA5, 8'h0F);
        partner.pulse(1'b0, 1'b1);
        clearSeen();
        chkBit(run, 1'b0);
        partner.set(1'b0, 13'h0123, 8'h00, 8'h00, 8'h5A, 8'hF0);
        repeat (2) @(posedge clk);
        chkBit(oscOn, 1'b0);
        chk({16'h0000, pOe, pOut}, 32'h0000_0FA5);
        chk({19'h0, rpc}, 32'h0000_0124);
        rdChk(IDX_STATUS, 32'h0000_0011);
        waitFor(1'b1, 100, n, hit);
        chkBit(hit, 1'b1);
        chkBit(seen, 1'b0);
        rdChk(IDX_STATUS, 32'h0000_0000);
        done("sleep");
        // pending enabled flag turns sleep into no-op
        apb(1'b1, IDX_OPTION, 32'h0000_000F);
        partner.pulse(1'b1, 1'b0);
        partner.set(1'b0, 13'h0200, 8'h04, 8'h04, 8'h00, 8'h00);
        partner.pulse(1'b0, 1'b1);
        @(negedge clk);
        chkBit(run, 1'b1);
        rdChk(IDX_STATUS, 32'h0000_0018);
        // every source: unenabled flags stay asleep, enabled wakes
        for (int i = 0; i < 8; i++) begin
            oh = 8'h01 << i;
            partner.set(i[0], 13'h0200, 8'h00, oh, 8'h00, 8'h00);
            partner.pulse(1'b0, 1'b1);
            partner.set(i[0], 13'h0200, ~oh, oh, 8'h00, 8'h00);
            waitFor(1'b1, 10, n, hit);
            chkBit(hit, 1'b0);
            partner.set(i[0], 13'h0200, 8'hFF, oh, 8'h00, 8'h00);
            waitFor(1'b1, 10, n, hit);
            chkBit(hit, 1'b1);
            chkBit(toVec, i[0]);
            partner.set(1'b0, 13'h0200, 8'h00, 8'h00, 8'h00, 8'h00);
            rdChk(IDX_STATUS, 32'h0000_0010);
        end
        // flag rising while sleep executes: sleep completes, then wakes
        partner.set(1'b0, 13'h0200, 8'h00, 8'h01, 8'h00, 8'h00);
        fork
            partner.pulse(1'b0, 1'b1);
            begin
                @(posedge clk);
                partner.set(1'b0, 13'h0200, 8'h01, 8'h01, 8'h00, 8'h00);
            end
        join
        waitFor(1'b1, 10, n, hit);
        chkBit(hit, 1'b1);
        partner.set(1'b0, 13'h0200, 8'h00, 8'h00, 8'h00, 8'h00);
        rdChk(IDX_STATUS, 32'h0000_0010);
        done("interrupts");
        // program mode: id words, crystal oscillator
        apb(1'b1, IDX_CTRL, 32'h0000_0001);
        for (int i = 0; i < ID_WORDS; i++) begin
            apb(1'b1, IDX_ID0 + 16'(i), 32'h0000_000A + 32'(i));
        end
        for (int i = 0; i < ID_WORDS; i++) begin
            rdChk(IDX_ID0 + 16'(i), 32'h0000_000A + 32'(i));
        end
        apb(1'b1, IDX_CONFIG, 32'h0000_0034);
        rdChk(IDX_CONFIG, 32'h0000_0034);
        chkBit(pmv, 1'b1);
        apb(1'b1, IDX_CONFIG, 32'h0000_0004);
        repeat (2) @(negedge clk);
        chkBit(pmv, 1'b0);
        apb(1'b1, IDX_CONFIG, 32'h0000_0034);
        apb(1'b1, IDX_CTRL, 32'h0000_0000);
        partner.set(1'b0, 13'h0300, 8'h00, 8'h01, 8'h00, 8'h00);
        partner.pulse(1'b0, 1'b1);
        partner.set(1'b0, 13'h0300, 8'h01, 8'h01, 8'h00, 8'h00);
        waitFor(1'b1, 1100, n, hit);
        chkBit(n >= 1022 && n <= 1032, 1'b1);
        partner.set(1'b0, 13'h0300, 8'h00, 8'h00, 8'h00, 8'h00);
        done("startup");
        // watchdog disabled by configuration
        apb(1'b1, IDX_CTRL, 32'h0000_0001);
        apb(1'b1, IDX_CONFIG, 32'h0000_0033);
        apb(1'b1, IDX_CTRL, 32'h0000_0000);
        apb(1'b1, IDX_OPTION, 32'h0000_0008);
        clearSeen();
        repeat (100) @(posedge clk);
        chkBit(seen, 1'b0);
        // master reset pin during sleep
        partner.pulse(1'b0, 1'b1);
        @(posedge clk);
        rstPinN <= 1'b0;
        waitFor(1'b0, 12, n, hit);
        chkBit(hit, 1'b1);
        @(negedge clk);
        chkBit(run, 1'b1);
        rstPinN <= 1'b1;
        repeat (8) @(posedge clk);
        done("reset pin");
        wrapUp();
    end
endmodule // tb_watchdog_sleep_wake_control
`default_nettype wire
